// File: bench/tmd_detector_tb.sv
/* Self-checking bench for the transient motion detector.
   Assumes the host model drives the register port. */
`timescale 1ns/100ps
`include "tmd_consts.svh"
module tmd_detector_tb;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic sample_valid = 1'b0;
    logic [11:0] sample_x = 12'h000;
    logic [11:0] sample_y = 12'h000;
    logic [11:0] sample_z = 12'h000;
    logic [3:0] reg_addr;
    logic [11:0] reg_wdata, reg_rdata, v;
    logic reg_wr, reg_rd, transient_irq, irq;
    int errors = 0;
    int checked = 0;
    always #2 clock = ~clock;
    tmd_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    tmd_detector uut (.clock(clock), .srst(srst), .sample_valid(sample_valid),
        .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .transient_irq(transient_irq), .irq(irq));
    task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One sample; X qualifies or sits exactly at threshold, Y and Z always large
    task automatic smp(input logic q);
        @(posedge clock);
        sample_valid <= 1'b1;
        sample_x <= q ? 12'h101 : 12'h100;
        sample_y <= 12'h7FF;
        sample_z <= 12'h7FF;
        @(posedge clock);
        sample_valid <= 1'b0;
        #1;
    endtask
    task automatic run(input logic [11:0] c, input logic [11:0] d, input logic [7:0] p, int n);
        @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        host.configure(c, 12'h100, d);
        for (int i = 0; i < n; i++) smp(p[i]);
    endtask
    initial begin
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        host.rd(`TMD_OFS_MODE, v); chk("mode", v, 12'h000);
        host.wr(`TMD_OFS_CTRL, 12'h001);
        host.rd(`TMD_OFS_MODE, v); chk("mode", v, 12'h001);
        host.wr(`TMD_OFS_CFG, 12'h03F);
        host.rd(`TMD_OFS_CFG, v); chk("locked", v, 12'h000);
        host.wr(`TMD_OFS_CTRL, 12'h003);
        host.rd(`TMD_OFS_MODE, v); chk("mode", v, 12'h002);
        host.rd(4'hF, v); chk("unmapped", v, 12'h000);
        host.wr(`TMD_OFS_CTRL, 12'h004);
        host.rd(`TMD_OFS_CFG, v); chk("cfg", v, 12'h01E);
        host.rd(`TMD_OFS_THRESH, v); chk("thresh", v, 12'h0C0);
        host.rd(`TMD_OFS_DEBOUNCE, v); chk("debounce", v, 12'h008);
        $display("test registers done");
        run(12'h013, 12'h002, 8'h03, 2);
        chk("early", transient_irq, 12'h000);
        smp(1'b1); chk("fired", transient_irq, 12'h001);
        chk("irq", irq, 12'h001);
        smp(1'b0); smp(1'b0); chk("held", transient_irq, 12'h001);
        host.rd(`TMD_OFS_EVENT, v); chk("event", v, 12'h009);
        host.rd(`TMD_OFS_IRQ_STAT, v); chk("stat", v, 12'h002);
        chk("irq clr", irq, 12'h000);
        chk("latch clr", transient_irq, 12'h000);
        $display("test latched done");
        run(12'h013, 12'h002, 8'h1B, 5); chk("clear", transient_irq, 12'h000);
        run(12'h033, 12'h002, 8'h1B, 5); chk("decrement", transient_irq, 12'h001);
        $display("test debounce done");
        run(12'h003, 12'h002, 8'h07, 3); chk("unl fire", transient_irq, 12'h001);
        smp(1'b0); chk("unl drop", transient_irq, 12'h000);
        host.rd(`TMD_OFS_EVENT, v); chk("unl event", v, 12'h001);
        chk("unl irq", irq, 12'h001);
        host.rd(`TMD_OFS_IRQ_STAT, v); chk("unl stat", v, 12'h003);
        $display("test unlatched done");
        for (int b = 0; b < 2; b++) begin
            run(12'h012 | b, 12'h001, 8'h0F, 4);
            chk("bypass", transient_irq, b);
        end
        $display("test bypass done");
        summarize();
    end
    initial begin
        #20000;
        errors++;
        summarize();
    end
endmodule

// File: bench/tmd_host_model.sv
/* Host controller model: register strobe port master.
   Assumes one clock; strobes sampled on its rising edge. */
`timescale 1ns/100ps
`include "tmd_consts.svh"
module tmd_host_model (
    // Clock
    input wire logic clock,
    // Register port
    output logic [3:0] reg_addr,
    output logic [11:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [11:0] reg_rdata
);
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 12'h000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [3:0] a, input logic [11:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [11:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Standby first, then settings, then back to active
    task automatic configure(input logic [11:0] c, input logic [11:0] t, input logic [11:0] d);
        wr(`TMD_OFS_CTRL, 12'h000);
        wr(`TMD_OFS_CFG, c);
        wr(`TMD_OFS_THRESH, t);
        wr(`TMD_OFS_DEBOUNCE, d);
        wr(`TMD_OFS_IRQ_MASK, 12'h002);
        wr(`TMD_OFS_CTRL, 12'h001);
    endtask
endmodule

// File: common/tmd_consts.svh
/*
 Constants for the transient motion detector: register offsets, field positions,
 reset and factory values. Assumes inclusion by bare name from design files.
*/
`ifndef TMD_CONSTS_SVH
`define TMD_CONSTS_SVH
`define TMD_OFS_CTRL 4'h0
`define TMD_OFS_CFG 4'h1
`define TMD_OFS_THRESH 4'h2
`define TMD_OFS_DEBOUNCE 4'h3
`define TMD_OFS_EVENT 4'h4
`define TMD_OFS_MODE 4'h5
`define TMD_OFS_IRQ_STAT 4'h6
`define TMD_OFS_IRQ_MASK 4'h7
`define TMD_CTRL_ACTIVE 0
`define TMD_CTRL_SLEEP_REQ 1
`define TMD_CTRL_DEFAULTS 2
`define TMD_CFG_BYPASS 0
`define TMD_CFG_EN_X 1
`define TMD_CFG_EN_Y 2
`define TMD_CFG_EN_Z 3
`define TMD_CFG_LATCH 4
`define TMD_CFG_DEC_MODE 5
`define TMD_EVT_X 0
`define TMD_EVT_Y 1
`define TMD_EVT_Z 2
`define TMD_EVT_ACTIVE 3
`define TMD_FACT_CFG 8'h1E
`define TMD_FACT_THRESH 12'h0C0
`define TMD_FACT_DEBOUNCE 8'h08
`define TMD_RST_CFG 8'h00
`define TMD_RST_THRESH 12'h000
`define TMD_RST_DEBOUNCE 8'h00
`define TMD_RST_MASK 2'h0
`endif

// File: common/tmd_pkg.sv
/*
 Types for the transient motion detector.
 Assumes tmd_consts.svh carries the numeric constants.
*/
package tmd_pkg;
    typedef enum logic [1:0] {
        TMD_STANDBY = 2'b00,
        TMD_WAKE = 2'b01,
        TMD_SLEEP = 2'b10
    } tmd_state_e;
    typedef logic [11:0] tmd_sample_t;
endpackage

// File: hw/tmd_detector.sv
/*
 Transient motion detector: per-axis threshold compare on filtered or raw
 samples, debounce counter, optional latch, registers on a plain strobe port.
 Assumes samples arrive as signed 12-bit words with a one-cycle valid, on clock.
*/
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "tmd_consts.svh"
module tmd_detector
    import tmd_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Samples
    input wire logic sample_valid,
    input wire logic [11:0] sample_x,
    input wire logic [11:0] sample_y,
    input wire logic [11:0] sample_z,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [11:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [11:0] reg_rdata,
    // Event outputs
    output logic transient_irq,
    output logic irq
);
    logic active;
    logic sleep_req;
    logic [7:0] cfg;
    logic [11:0] thresh;
    logic [7:0] debounce;
    logic [7:0] count;
    logic [3:0] event_stat;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    tmd_state_e mode;
    logic [11:0] prev_x, prev_y, prev_z;
    logic [11:0] hp_x, hp_y, hp_z;

    // Decode
    wire wr_ctrl = reg_wr && reg_addr == `TMD_OFS_CTRL;
    wire defaults = wr_ctrl && reg_wdata[`TMD_CTRL_DEFAULTS];
    wire standby = mode == TMD_STANDBY;
    wire cfg_ok = standby;
    wire wr_cfg = reg_wr && reg_addr == `TMD_OFS_CFG && cfg_ok;
    wire wr_thr = reg_wr && reg_addr == `TMD_OFS_THRESH && cfg_ok;
    wire wr_deb = reg_wr && reg_addr == `TMD_OFS_DEBOUNCE && cfg_ok;
    wire rd_evt = reg_rd && reg_addr == `TMD_OFS_EVENT;
    wire rd_irq = reg_rd && reg_addr == `TMD_OFS_IRQ_STAT;
    wire wr_mask = reg_wr && reg_addr == `TMD_OFS_IRQ_MASK;
    wire latch_en = cfg[`TMD_CFG_LATCH];
    wire dec_mode = cfg[`TMD_CFG_DEC_MODE];
    wire bypass_on = cfg[`TMD_CFG_BYPASS];
    wire en_x = cfg[`TMD_CFG_EN_X];
    wire en_y = cfg[`TMD_CFG_EN_Y];
    wire en_z = cfg[`TMD_CFG_EN_Z];

    // High-pass: sample minus previous sample
    assign hp_x = sample_x - prev_x;
    assign hp_y = sample_y - prev_y;
    assign hp_z = sample_z - prev_z;
    wire [11:0] use_x = bypass_on ? sample_x : hp_x;
    wire [11:0] use_y = bypass_on ? sample_y : hp_y;
    wire [11:0] use_z = bypass_on ? sample_z : hp_z;
    wire [11:0] mag_x = use_x[11] ? 12'(-use_x) : use_x;
    wire [11:0] mag_y = use_y[11] ? 12'(-use_y) : use_y;
    wire [11:0] mag_z = use_z[11] ? 12'(-use_z) : use_z;
    wire [2:0] axis_hit = {
        en_z && mag_z > thresh,
        en_y && mag_y > thresh,
        en_x && mag_x > thresh};
    wire cond = |axis_hit && active;
    wire fire = cond && count >= debounce;
    wire [7:0] next_count = cond ? (fire ? count : 8'(count + 8'h01))
        : (dec_mode ? (count != 8'h00 ? 8'(count - 8'h01) : 8'h00)
        : 8'h00);
    wire [3:0] fire_stat = {1'b1, axis_hit};
    wire hold = latch_en && event_stat[`TMD_EVT_ACTIVE] && !rd_evt;
    wire [3:0] next_event = (sample_valid && fire) ? fire_stat
        : hold ? event_stat
        : latch_en ? (rd_evt ? 4'h0 : event_stat)
        : (sample_valid && !cond) ? {1'b0, event_stat[2:0]}
        : event_stat;
    wire fire_evt = sample_valid && fire;
    wire [1:0] ev_set = {fire_evt, fire_evt && !latch_en};
    wire [1:0] next_irq_stat = (rd_irq ? 2'h0 : irq_stat) | ev_set;
    tmd_state_e next_mode;
    always_comb begin
        case ({active, sleep_req})
            2'b10: next_mode = TMD_WAKE;
            2'b11: next_mode = TMD_SLEEP;
            default: next_mode = TMD_STANDBY;
        endcase
    end
    wire [11:0] ctrl_word = {10'h000, sleep_req, active};
    wire [11:0] cfg_word = {4'h0, cfg};
    wire [11:0] deb_word = {4'h0, debounce};
    wire [11:0] evt_word = {8'h00, event_stat};
    wire [11:0] mode_word = {10'h000, mode};
    wire [11:0] stat_word = {10'h000, irq_stat};
    wire [11:0] mask_word = {10'h000, irq_mask};
    wire [11:0] rd_mux = reg_addr == `TMD_OFS_CTRL ? ctrl_word
        : reg_addr == `TMD_OFS_CFG ? cfg_word
        : reg_addr == `TMD_OFS_THRESH ? thresh
        : reg_addr == `TMD_OFS_DEBOUNCE ? deb_word
        : reg_addr == `TMD_OFS_EVENT ? evt_word
        : reg_addr == `TMD_OFS_MODE ? mode_word
        : reg_addr == `TMD_OFS_IRQ_STAT ? stat_word
        : reg_addr == `TMD_OFS_IRQ_MASK ? mask_word
        : 12'h000;

    // Control and configuration
    always_ff @(posedge clock) begin
        if (srst) begin
            active <= 1'b0;
            sleep_req <= 1'b0;
            cfg <= `TMD_RST_CFG;
            thresh <= `TMD_RST_THRESH;
            debounce <= `TMD_RST_DEBOUNCE;
            irq_mask <= `TMD_RST_MASK;
        end else begin
            if (wr_ctrl) begin
                active <= reg_wdata[`TMD_CTRL_ACTIVE];
                sleep_req <= reg_wdata[`TMD_CTRL_SLEEP_REQ];
            end
            if (defaults) begin
                cfg <= `TMD_FACT_CFG;
                thresh <= `TMD_FACT_THRESH;
                debounce <= `TMD_FACT_DEBOUNCE;
            end else begin
                if (wr_cfg) cfg <= reg_wdata[7:0];
                if (wr_thr) thresh <= reg_wdata;
                if (wr_deb) debounce <= reg_wdata[7:0];
            end
            if (wr_mask) irq_mask <= reg_wdata[1:0];
        end
    end

    // Detection datapath
    always_ff @(posedge clock) begin
        if (srst) begin
            prev_x <= 12'h000;
            prev_y <= 12'h000;
            prev_z <= 12'h000;
            count <= 8'h00;
        end else if (sample_valid) begin
            prev_x <= sample_x;
            prev_y <= sample_y;
            prev_z <= sample_z;
            count <= next_count;
        end else if (!active) begin
            count <= 8'h00;
        end
    end

    // Event status and transient output
    always_ff @(posedge clock) begin
        if (srst) begin
            event_stat <= 4'h0;
            transient_irq <= 1'b0;
        end else begin
            event_stat <= next_event;
            transient_irq <= next_event[`TMD_EVT_ACTIVE];
        end
    end

    // Interrupt status and line
    always_ff @(posedge clock) begin
        if (srst) begin
            irq_stat <= 2'h0;
            irq <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq <= |(next_irq_stat & irq_mask);
        end
    end

    // Operating state
    always_ff @(posedge clock) begin
        if (srst) begin
            mode <= TMD_STANDBY;
        end else begin
            mode <= next_mode;
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata <= 12'h000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 12'h000;
        end
    end

    // Checks
    debounce_gate_a: assert property (@(posedge clock) disable iff (srst)
        $rose(event_stat[3]) |-> $past(count) >= $past(debounce))
        else $error("event before debounce");
    latch_hold_a: assert property (@(posedge clock) disable iff (srst)
        (latch_en && event_stat[3] && !rd_evt && $stable(cfg)) |=> event_stat[3])
        else $error("latched event dropped");
    read_clear_a: assert property (@(posedge clock) disable iff (srst)
        (latch_en && rd_evt && !fire_evt) |=> !event_stat[3])
        else $error("read did not clear");
    unlatch_drop_a: assert property (@(posedge clock) disable iff (srst)
        (!latch_en && sample_valid && !cond) |=> !event_stat[3])
        else $error("unlatched event held");
    below_thresh_a: assert property (@(posedge clock) disable iff (srst)
        (sample_valid && axis_hit == 3'h0) |=> !$rose(event_stat[3]))
        else $error("fired below threshold");
    clear_mode_a: assert property (@(posedge clock) disable iff (srst)
        (sample_valid && !dec_mode && !cond) |=> count == 8'h00)
        else $error("clear mode kept count");
    dec_mode_a: assert property (@(posedge clock) disable iff (srst)
        (sample_valid && dec_mode && !cond && count != 8'h00) |=> count == $past(count) - 8'h01)
        else $error("decrement mode wrong");
    axis_en_a: assert property (@(posedge clock) disable iff (srst)
        $rose(event_stat[3]) |-> (event_stat[2:0] & ~{cfg[3], cfg[2], cfg[1]}) == 3'h0)
        else $error("disabled axis reported");
    mode_view_a: assert property (@(posedge clock) disable iff (srst)
        !active |=> mode == TMD_STANDBY)
        else $error("mode wrong in standby");
    defaults_a: assert property (@(posedge clock) disable iff (srst)
        defaults |=> thresh == `TMD_FACT_THRESH && debounce == `TMD_FACT_DEBOUNCE)
        else $error("defaults not loaded");
    cov_latch_c: cover property (@(posedge clock) latch_en && $rose(transient_irq));
    cov_unlatch_c: cover property (@(posedge clock) !latch_en && $fell(transient_irq));
    cov_dec_c: cover property (@(posedge clock) dec_mode && sample_valid && !cond && count != 8'h00);
    cov_bypass_c: cover property (@(posedge clock) fire_evt && bypass_on);
    cov_defaults_c: cover property (@(posedge clock) defaults);
    cfg_lock_a: assert property (@(posedge clock) disable iff (srst)
        (!standby && !defaults) |=> $stable(cfg) && $stable(thresh) && $stable(debounce))
        else $error("settings changed while active");
    rdata_idle_a: assert property (@(posedge clock) disable iff (srst)
        !reg_rd |=> reg_rdata == 12'h000)
        else $error("read data without strobe");
    irq_hold_a: assert property (@(posedge clock) disable iff (srst)
        (irq_stat[1] && !rd_irq) |=> irq_stat[1])
        else $error("status bit dropped");
    irq_set_a: assert property (@(posedge clock) disable iff (srst)
        fire_evt |=> irq_stat[1])
        else $error("status bit not set");
    irq_clear_a: assert property (@(posedge clock) disable iff (srst)
        (rd_irq && !fire_evt) |=> irq_stat == 2'h0)
        else $error("status read did not clear");
    irq_line_a: assert property (@(posedge clock) disable iff (srst)
        ((irq_stat & irq_mask) != 2'h0 && !rd_irq) |=> irq)
        else $error("interrupt line low");
    irq_quiet_a: assert property (@(posedge clock) disable iff (srst)
        (irq_mask == 2'h0) |=> !irq)
        else $error("masked interrupt raised");
    mask_write_a: assert property (@(posedge clock) disable iff (srst)
        wr_mask |=> irq_mask == $past(reg_wdata[1:0]))
        else $error("mask not written");
    mode_sleep_a: assert property (@(posedge clock) disable iff (srst)
        (active && sleep_req) |=> mode == TMD_SLEEP)
        else $error("mode wrong in sleep");
    mode_wake_a: assert property (@(posedge clock) disable iff (srst)
        (active && !sleep_req) |=> mode == TMD_WAKE)
        else $error("mode wrong in wake");
    idle_count_a: assert property (@(posedge clock) disable iff (srst)
        (!active && !sample_valid) |=> count == 8'h00)
        else $error("count kept in standby");
    count_step_a: assert property (@(posedge clock) disable iff (srst)
        (sample_valid && cond && count < debounce) |=> count == $past(count) + 8'h01)
        else $error("count did not step");
    fire_axes_a: assert property (@(posedge clock) disable iff (srst)
        fire_evt |=> event_stat == {1'b1, $past(axis_hit)})
        else $error("event axes wrong");
    standby_quiet_a: assert property (@(posedge clock) disable iff (srst)
        (!active && sample_valid) |=> !$rose(event_stat[3]))
        else $error("event in standby");
    raw_select_a: assert property (@(posedge clock) disable iff (srst)
        (sample_valid && bypass_on && en_x && !sample_x[11] && sample_x > thresh
            && active && count >= debounce) |=> event_stat[3])
        else $error("raw sample missed");
    filtered_select_a: assert property (@(posedge clock) disable iff (srst)
        (sample_valid && !bypass_on && en_x && !hp_x[11] && hp_x > thresh
            && active && count >= debounce) |=> event_stat[3])
        else $error("filtered sample missed");
    unlatch_axes_a: assert property (@(posedge clock) disable iff (srst)
        (!latch_en && sample_valid && !cond) |=> event_stat[2:0] == $past(event_stat[2:0]))
        else $error("latest axes lost");
    defaults_cfg_a: assert property (@(posedge clock) disable iff (srst)
        defaults |=> cfg == `TMD_FACT_CFG)
        else $error("default config not loaded");
endmodule
